/* File: aic_pkg.sv */
package aic_pkg;

  // ==========================================================
  // Slave addressing
  localparam logic [6:0] BASE_ADDR_A = 7'h34;
  localparam logic [6:0] BASE_ADDR_B = 7'h32;
  localparam logic [6:0] BASE_ADDR_C = 7'h36;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;

  // ==========================================================
  // Configuration and setup byte layout
  localparam int CFG_SCAN_HI = 6;
  localparam int CFG_SCAN_LO = 5;
  localparam int CFG_CS_HI = 2;
  localparam int CFG_CS_LO = 1;
  localparam int CFG_PAIR = 0;
  localparam int SET_MARK = 7;
  localparam int SET_REF_ROLE = 5;
  localparam int SET_CLK_SRC = 3;
  localparam int SET_BIPOLAR = 2;
  localparam int SET_KEEP_CFG = 1;
  localparam logic [7:0] CFG_RESET = 8'h01;
  localparam logic [7:0] SETUP_RESET = 8'h82;
  localparam logic [1:0] SCAN_UP = 2'h0;
  localparam logic [1:0] SCAN_BURST = 2'h1;
  localparam logic [1:0] SCAN_MON = 2'h2;

  // ==========================================================
  // Timing and counts
  localparam logic [3:0] CONV_TICKS = 4'hc;
  localparam logic [3:0] BURST_LEN = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BYTE_CLKS = 4'h9;
  localparam logic [3:0] EXT_SAMPLE_BIT = 4'h1;
  localparam logic [7:0] OSC_DIV_DEFAULT = 8'h04;

  // ==========================================================
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BYTES = 8'h08;

  // ==========================================================
  // Types
  typedef logic [3:0][11:0] aic_ain_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_IGN, ST_WR, ST_CONV, ST_REL, ST_RD
  } aic_state_t;

  typedef struct packed {
    aic_state_t st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] asel_s;
    logic [3:0] bc;
    logic [7:0] sh;
    logic [7:0] cfg;
    logic [7:0] setup;
    logic [1:0] base_sel;
    logic hs;
    logic [7:0][11:0] mem;
    logic [3:0] n;
    logic [3:0] k;
    logic [3:0] rp;
    logic hi;
    logic [11:0] code;
    logic [3:0] tick;
    logic [7:0] div;
    logic track;
    logic [1:0] ch;
    logic drv_lvl;
    logic sda_oe;
    logic scl_oe;
    logic hready;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] waddr;
  } aic_regs_t;

endpackage : aic_pkg

/* File: aic_adc_i2c_slave.sv */
// Contract
// - Internal mode tracks 8th rise, samples 9th fall
// - Internal mode stretches clock until scan done
// - Results read in scan order, wrapping
// - Internal results only from latest read addressing
// - Reference pin dropped from up and monitor scans, reads ground if differential
// - Clock-source bit picks clock, internal default
// - Serial-clock mode tracks 9th rise, samples later
// - Serial-clock mode converts until master not-acknowledge
// - Monitor scan always uses internal oscillator
// - Pairing bit picks ground or differential
// - Unipolar binary clamped, bipolar two's complement
// - Power-on config is single-ended input zero
// - Nine clocks per byte, data stable high
// - Start and stop are data edges, clock high
// - Receiver acknowledges by low ninth bit
// - Seven-bit address, low bit from pin
// - Match own address, then follow direction bit
// - High-speed master code gets not-acknowledge, switch
// - Stop returns to standard/fast timing
// - Written byte top bit chooses setup or config
`timescale 1ns/1ps

module aic_adc_i2c_slave #(
  parameter logic [7:0] OSC_DIV = aic_pkg::OSC_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic address_select_pin,
  input wire aic_pkg::aic_ain_t ain_level,
  output logic track_o,
  output logic [1:0] ch_sel_o
);
  import aic_pkg::*;

  aic_regs_t r_reg;
  aic_regs_t r_next;
  logic scl_rise;
  logic scl_fall;
  logic sda_bit;
  logic start_cond;
  logic stop_cond;
  logic osc_en;
  logic ext_mode;
  logic addr_match;
  logic hs_code;
  logic ahb_take;
  logic [6:0] own_addr;
  logic [11:0] tx_word;
  logic [7:0] tx_byte;
  logic [3:0] conv_total;
  logic [31:0] rd_mux;

  // ==========================================================
  // Conversion helpers
  function automatic logic [11:0] conv_code(aic_ain_t ain, logic [1:0] ch,
                                            logic [7:0] cfg, logic [7:0] setup);
    logic [1:0] ni;
    logic [12:0] pv;
    logic [12:0] nv;
    logic [12:0] d;
    // Negative input is the other member of the pair
    ni = {ch[1], ~ch[0]};
    pv = {1'b0, ain[ch]};
    nv = {1'b0, ain[ni]};
    if (setup[SET_REF_ROLE] && ch == 2'h3) begin
      pv = 13'h0000;
    end
    if (setup[SET_REF_ROLE] && ni == 2'h3) begin
      nv = 13'h0000;
    end
    d = pv - nv;
    if (cfg[CFG_PAIR]) begin
      return ain[ch];
    end else if (setup[SET_BIPOLAR]) begin
      return d[12:1];
    end else begin
      return d[12] ? 12'h000 : d[11:0];
    end
  endfunction : conv_code

  function automatic logic [3:0] scan_count(logic [7:0] cfg, logic [7:0] setup);
    logic [1:0] ul;
    ul = cfg[CFG_CS_HI:CFG_CS_LO];
    if (setup[SET_REF_ROLE] && ul == 2'h3) begin
      ul = 2'h2;
    end
    case (cfg[CFG_SCAN_HI:CFG_SCAN_LO])
      SCAN_BURST: begin
        return BURST_LEN;
      end
      SCAN_UP, SCAN_MON: begin
        return {2'h0, ul} + 4'h1;
      end
      default: begin
        return 4'h1;
      end
    endcase
  endfunction : scan_count

  function automatic logic [1:0] scan_chan(logic [3:0] k, logic [7:0] cfg);
    logic [1:0] sm;
    sm = cfg[CFG_SCAN_HI:CFG_SCAN_LO];
    if (sm == SCAN_UP || sm == SCAN_MON) begin
      return k[1:0];
    end else begin
      return cfg[CFG_CS_HI:CFG_CS_LO];
    end
  endfunction : scan_chan

  // ==========================================================
  // Line conditions
  // Edges come from the second and third sync stages
  assign scl_rise = r_reg.scl_s[1] & ~r_reg.scl_s[2];
  assign scl_fall = ~r_reg.scl_s[1] & r_reg.scl_s[2];
  assign sda_bit = r_reg.sda_s[1];
  assign start_cond = r_reg.scl_s[1] & r_reg.scl_s[2] & r_reg.sda_s[2] & ~r_reg.sda_s[1];
  assign stop_cond = r_reg.scl_s[1] & r_reg.scl_s[2] & ~r_reg.sda_s[2] & r_reg.sda_s[1];
  // Oscillator tick enable from the clock divider
  assign osc_en = (r_reg.div == OSC_DIV - 8'h01);
  // Monitor scans always run on the internal oscillator
  assign ext_mode = r_reg.setup[SET_CLK_SRC]
                    & (r_reg.cfg[CFG_SCAN_HI:CFG_SCAN_LO] != SCAN_MON);
  assign addr_match = (r_reg.sh[7:1] == own_addr);
  assign hs_code = (r_reg.sh[7:3] == HS_CODE_TOP);
  assign conv_total = scan_count(r_reg.cfg, r_reg.setup);
  assign tx_word = ext_mode ? r_reg.code : r_reg.mem[r_reg.rp[2:0]];
  // High byte carries four filler ones above the code
  assign tx_byte = r_reg.hi ? {4'hf, tx_word[11:8]} : tx_word[7:0];
  // Address phase accepted
  assign ahb_take = hsel & htrans[1] & hready;

  // ==========================================================
  // Own address
  always_comb begin
    case (r_reg.base_sel)
      2'h1: own_addr = {BASE_ADDR_B[6:1], r_reg.asel_s[1]};
      2'h2: own_addr = {BASE_ADDR_C[6:1], r_reg.asel_s[1]};
      default: own_addr = {BASE_ADDR_A[6:1], r_reg.asel_s[1]};
    endcase
  end

  // ==========================================================
  // Register read mux
  // Read data stands only for the data-phase cycle
  always_comb begin
    rd_mux = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      case (haddr[7:0])
        REG_CTRL: rd_mux = {30'h0, r_reg.base_sel};
        REG_STATUS: rd_mux = {24'h0, r_reg.n, ext_mode, r_reg.track, r_reg.scl_oe, r_reg.hs};
        REG_BYTES: rd_mux = {16'h0, r_reg.setup, r_reg.cfg};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.scl_s = {r_reg.scl_s[1:0], scl_i};
    r_next.sda_s = {r_reg.sda_s[1:0], sda_i};
    r_next.asel_s = {r_reg.asel_s[0], address_select_pin};
    r_next.div = osc_en ? 8'h00 : r_reg.div + 8'h01;

    // ==========================================================
    // Register bus slave, zero wait states
    // Writes land in the data phase, one cycle after the address
    r_next.wr_pend = ahb_take & hwrite & (hsize == 3'h2) & (haddr[31:8] == 24'h0);
    if (ahb_take) begin
      r_next.waddr = haddr[7:0];
    end
    if (r_reg.wr_pend && r_reg.waddr == REG_CTRL) begin
      r_next.base_sel = hwdata[1:0];
    end
    r_next.hrdata = (ahb_take && !hwrite) ? rd_mux : 32'h0;

    // ==========================================================
    // Serial slave
    if (start_cond) begin
      // Repeated start keeps the speed flag
      r_next.st = ST_ADDR;
      r_next.hs = r_reg.hs;
      r_next.bc = 4'h0;
      r_next.sda_oe = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.track = 1'b0;
    end else if (stop_cond) begin
      // Stop ends any transfer and high-speed timing
      r_next.st = ST_IDLE;
      r_next.hs = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.scl_oe = 1'b0;
      r_next.track = 1'b0;
    end else begin
      case (r_reg.st)
        ST_ADDR, ST_WR: begin
          // Eight data bits shift on rises, ninth is acknowledge
          if (scl_rise) begin
            r_next.bc = r_reg.bc + 4'h1;
            if (r_reg.bc < BYTE_BITS) begin
              r_next.sh = {r_reg.sh[6:0], sda_bit};
            end
            // Internal mode tracks from the read bit rise
            if (r_reg.st == ST_ADDR && r_reg.bc == BYTE_BITS - 4'h1 && sda_bit
                && r_reg.sh[6:0] == own_addr && !ext_mode) begin
              r_next.track = 1'b1;
              r_next.ch = scan_chan(4'h0, r_reg.cfg);
            end
            // Serial-clock mode tracks from the ninth rise
            if (r_reg.st == ST_ADDR && r_reg.bc == BYTE_BITS && addr_match
                && r_reg.sh[0] && ext_mode) begin
              r_next.track = 1'b1;
              r_next.ch = scan_chan(4'h0, r_reg.cfg);
            end
          end else if (scl_fall && r_reg.bc == BYTE_BITS) begin
            // Eighth fall: drive acknowledge
            if (r_reg.st == ST_WR) begin
              r_next.sda_oe = 1'b1;
              if (r_reg.sh[SET_MARK]) begin
                r_next.setup = r_reg.sh;
                if (!r_reg.sh[SET_KEEP_CFG]) begin
                  r_next.cfg = CFG_RESET;
                end
              end else begin
                r_next.cfg = r_reg.sh;
              end
            end else if (addr_match) begin
              r_next.sda_oe = 1'b1;
            end else if (!hs_code) begin
              r_next.st = ST_IGN;
            end
          end else if (scl_fall && r_reg.bc == BYTE_CLKS) begin
            // Ninth fall: direction, conversion or speed switch
            r_next.bc = 4'h0;
            r_next.sda_oe = 1'b0;
            if (r_reg.st == ST_ADDR) begin
              if (!addr_match) begin
                r_next.hs = 1'b1;
                r_next.st = ST_IGN;
              end else if (!r_reg.sh[0]) begin
                r_next.st = ST_WR;
              end else if (ext_mode) begin
                r_next.st = ST_RD;
                r_next.k = 4'h0;
                r_next.hi = 1'b1;
              end else begin
                r_next.st = ST_CONV;
                r_next.scl_oe = 1'b1;
                r_next.track = 1'b0;
                r_next.code = conv_code(ain_level, r_reg.ch, r_reg.cfg, r_reg.setup);
                r_next.n = conv_total;
                r_next.k = 4'h0;
                r_next.tick = 4'h0;
              end
            end
          end
        end
        ST_CONV: begin
          // One result per CONV_TICKS oscillator ticks, clock held low
          if (osc_en) begin
            r_next.tick = r_reg.tick + 4'h1;
            if (r_reg.tick == CONV_TICKS - 4'h1) begin
              r_next.mem[r_reg.k[2:0]] = r_reg.code;
              r_next.k = r_reg.k + 4'h1;
              r_next.tick = 4'h0;
              if (r_reg.k + 4'h1 == r_reg.n) begin
                r_next.st = ST_REL;
                r_next.rp = 4'h0;
                r_next.hi = 1'b1;
              end else begin
                r_next.ch = scan_chan(r_reg.k + 4'h1, r_reg.cfg);
                r_next.code = conv_code(ain_level, scan_chan(r_reg.k + 4'h1, r_reg.cfg),
                                        r_reg.cfg, r_reg.setup);
              end
            end
          end
        end
        ST_REL: begin
          // Release the clock once every result is stored
          r_next.scl_oe = 1'b0;
          r_next.st = ST_RD;
        end
        ST_RD: begin
          // Shift out on falls, master acknowledge on ninth rise
          if (scl_rise) begin
            r_next.bc = r_reg.bc + 4'h1;
            // Serial-clock mode samples on second rise of high byte
            if (ext_mode && r_reg.hi && r_reg.bc == EXT_SAMPLE_BIT) begin
              r_next.code = conv_code(ain_level, r_reg.ch, r_reg.cfg, r_reg.setup);
              r_next.track = 1'b0;
            end
            if (r_reg.bc == BYTE_BITS) begin
              if (sda_bit) begin
                r_next.st = ST_IGN;
                r_next.track = 1'b0;
              end else if (r_reg.hi) begin
                r_next.hi = 1'b0;
              end else if (ext_mode) begin
                r_next.hi = 1'b1;
                r_next.track = 1'b1;
                r_next.k = (r_reg.k + 4'h1 == conv_total) ? 4'h0 : r_reg.k + 4'h1;
                r_next.ch = scan_chan((r_reg.k + 4'h1 == conv_total) ? 4'h0
                                      : r_reg.k + 4'h1, r_reg.cfg);
              end else begin
                r_next.hi = 1'b1;
                r_next.rp = (r_reg.rp + 4'h1 == r_reg.n) ? 4'h0 : r_reg.rp + 4'h1;
              end
            end
          end else if (scl_fall) begin
            if (r_reg.bc == BYTE_CLKS) begin
              r_next.bc = 4'h0;
              r_next.sda_oe = ~tx_byte[7];
            end else if (r_reg.bc < BYTE_BITS) begin
              r_next.sda_oe = ~tx_byte[3'h7 - r_reg.bc[2:0]];
            end else begin
              r_next.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          // Ignored traffic: keep data released
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  // Lines reset high so no false edge follows reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.scl_s <= 3'h7;
      r_reg.sda_s <= 3'h7;
      r_reg.cfg <= CFG_RESET;
      r_reg.setup <= SETUP_RESET;
      r_reg.hready <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  // Open drain: only the enables toggle, levels stay low
  assign hreadyout = r_reg.hready;
  assign hrdata = r_reg.hrdata;
  assign hresp = r_reg.drv_lvl;
  assign scl_o = r_reg.drv_lvl;
  assign scl_oe = r_reg.scl_oe;
  assign sda_o = r_reg.drv_lvl;
  assign sda_oe = r_reg.sda_oe;
  assign track_o = r_reg.track;
  assign ch_sel_o = r_reg.ch;

endmodule : aic_adc_i2c_slave

/* File: aic_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// Port checker
module aic_checker #(
  parameter logic [7:0] OSC_DIV = aic_pkg::OSC_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic track_o,
  input wire logic [1:0] ch_sel_o
);
  import aic_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_open_drain: assert property (!scl_o && !sda_o)
    else $error("line driven high");
  chk_sda_clk_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed with clock high");
  chk_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*6])
    else $error("low data bit not held");
  chk_stretch_start: assert property ($rose(scl_oe) |-> !$past(scl_i) && !track_o)
    else $error("stretch began outside hold");
  chk_stretch_len: assert property ($rose(scl_oe) |-> scl_oe [*8])
    else $error("stretch shorter than a conversion");
  chk_reset_state: assert property ($rose(rstn) |-> !scl_oe && !sda_oe && !track_o && ch_sel_o == 2'h0)
    else $error("bad state after reset");
  chk_read_idle: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
    else $error("read data outside data phase");
  chk_no_wait: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  cover property ($rose(scl_oe));
  cover property ($rose(track_o) && scl_i);
  cover property ($rose(sda_oe));
endmodule : aic_checker

/* File: aic_i2c_master.sv */
`timescale 1ns/1ps
// ==========================================================
// Two-wire bus master model, 400 ns bit period
module aic_i2c_master (
  input wire logic clk,
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  import aic_pkg::*;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  // One bit: data set in low phase, waits out stretching
  task automatic bit_io(input logic b, output logic r);
    int n;
    wt(2);
    sda_drv <= b;
    wt(3);
    scl_drv <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (scl_line !== 1'b1 && n < 4000);
    wt(1);
    r = sda_line;
    wt(1);
    scl_drv <= 1'b0;
  endtask : bit_io
  task automatic start_c();
    wt(2);
    sda_drv <= 1'b1;
    wt(2);
    scl_drv <= 1'b1;
    wt(4);
    sda_drv <= 1'b0;
    wt(4);
    scl_drv <= 1'b0;
  endtask : start_c
  task automatic stop_c();
    wt(2);
    sda_drv <= 1'b0;
    wt(3);
    scl_drv <= 1'b1;
    wt(4);
    sda_drv <= 1'b1;
    wt(4);
  endtask : stop_c
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q,
                      output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a_out);
  endtask : xfer
endmodule : aic_i2c_master

/* File: aic_testbench.sv */
`timescale 1ns/1ps
// ==========================================================
// Top-level bench
module testbench;
  import aic_pkg::*;
  logic clk = 1'b0;
  logic rstn, hsel, hwrite, hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, track_o;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, ch_sel_o;
  logic [2:0] hsize;
  logic m_scl, m_sda, pin, ack;
  logic [7:0] hb, lb;
  logic [6:0] sa;
  aic_ain_t ain;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h0000a4f2;
  wire scl_line = m_scl & ~scl_oe;
  wire sda_line = m_sda & ~sda_oe;
  always #25 clk = ~clk;
  aic_adc_i2c_slave #(.OSC_DIV(8'h02)) dut (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .address_select_pin(pin), .ain_level(ain), .track_o(track_o),
    .ch_sel_o(ch_sel_o));
  aic_i2c_master m (.clk(clk), .scl_line(scl_line), .sda_line(sda_line), .scl_drv(m_scl),
    .sda_drv(m_sda));
  function automatic logic [11:0] rnd12();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[11:0];
  endfunction : rnd12
  function automatic logic [11:0] exp_res(input int c, input int k);
    logic signed [12:0] d;
    d = $signed({1'b0, ain[0]}) - $signed({1'b0, ain[1]});
    case (c)
      1: return d[12:1];
      2: return d[12] ? 12'h000 : d[11:0];
      3, 5: return ain[1];
      default: return ain[k % 3];
    endcase
  endfunction : exp_res
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic run_case(input int c);
    logic [7:0] st [6] = '{8'ha2, 8'h86, 8'h82, 8'h8a, 8'h8a, 8'h82};
    logic [7:0] cf [6] = '{8'h07, 8'h60, 8'h60, 8'h63, 8'h45, 8'h23};
    int n;
    n = (c == 1 || c == 2) ? 2 : (c == 0) ? 4 : (c == 5) ? 9 : 3;
    m.start_c();
    m.xfer({sa, 1'b0}, 1'b1, hb, ack);
    chk(ack, 1'b0);
    m.xfer(st[c], 1'b1, hb, ack);
    m.xfer(cf[c], 1'b1, hb, ack);
    chk(ack, 1'b0);
    m.start_c();
    m.xfer({sa, 1'b1}, 1'b1, hb, ack);
    chk(ack, 1'b0);
    for (int k = 0; k < n; k++) begin
      m.xfer(8'hff, 1'b0, hb, ack);
      m.xfer(8'hff, k == n - 1, lb, ack);
      chk({hb, lb}, {4'hf, exp_res(c, k)});
    end
    m.stop_c();
    ahb(1'b0, REG_BYTES, 32'h0, rd);
    chk(rd[7:0], cf[c]);
  endtask : run_case
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ain = '0;
    pin = ^rnd12();
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    ahb(1'b0, REG_BYTES, 32'h0, rd);
    chk(rd, {16'h0, SETUP_RESET, CFG_RESET});
    ahb(1'b0, 8'h0c, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    sa = {BASE_ADDR_B[6:1], pin};
    m.start_c();
    m.xfer({BASE_ADDR_C[6:1], pin, 1'b0}, 1'b1, hb, ack);
    chk(ack, 1'b1);
    m.stop_c();
    for (int c = 0; c < 6; c++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        for (int i = 0; i < 4; i++) ain[i] <= (p == 1 && i == 1) ? 12'hfff : rnd12();
        run_case(c);
      end
    end
    m.start_c();
    m.xfer(8'h08, 1'b1, hb, ack);
    chk(ack, 1'b1);
    m.start_c();
    m.xfer({sa, 1'b0}, 1'b1, hb, ack);
    chk(ack, 1'b0);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd[0], 1'b1);
    m.stop_c();
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk(rd[0], 1'b0);
    test_done();
  end
endmodule : testbench

bind aic_adc_i2c_slave aic_checker #(.OSC_DIV(OSC_DIV)) u_chk (.clk(clk), .rstn(rstn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
  .sda_o(sda_o), .sda_oe(sda_oe), .track_o(track_o), .ch_sel_o(ch_sel_o));
